// >>> odt_pkg.sv
// shared constants and types for the termination control ends
package odt_pkg;
  localparam int RZQ_OHMS = 240;
  localparam logic [2:0] NOM_OFF   = 3'h0;
  localparam logic [2:0] NOM_DIV4  = 3'h1;
  localparam logic [2:0] NOM_DIV2  = 3'h2;
  localparam logic [2:0] NOM_DIV6  = 3'h3;
  localparam logic [2:0] NOM_DIV12 = 3'h4;
  localparam logic [2:0] NOM_DIV8  = 3'h5;
  localparam logic [1:0] WR_OFF    = 2'h0;
  localparam logic [1:0] WR_DIV4   = 2'h1;
  localparam logic [1:0] WR_DIV2   = 2'h2;
  localparam logic [1:0] WR_RSVD   = 2'h3;
  localparam logic [1:0] AL_ZERO   = 2'h0;
  localparam logic [1:0] AL_CL1    = 2'h1;
  localparam logic [1:0] AL_CL2    = 2'h2;
  localparam logic [1:0] BURST_FIX8 = 2'h0;
  localparam logic [1:0] BURST_OTF  = 2'h1;
  localparam logic [1:0] BURST_FIX4 = 2'h2;
  localparam logic [5:0] LAT_OFFSET = 6'h02;
  localparam logic [3:0] MIN_HIGH_SHORT = 4'h4;
  localparam logic [3:0] MIN_HIGH_LONG  = 4'h6;
  localparam int CLK_PERIOD_NS   = 25;
  localparam int ASYNC_MIN_NS    = 1;
  localparam int ASYNC_MAX_NS    = 9;
  localparam int ASYNC_CYC_RAW   = ASYNC_MAX_NS / CLK_PERIOD_NS;
  localparam logic [5:0] ASYNC_DELAY_CYC =
    (ASYNC_CYC_RAW < 1) ? 6'h01 : 6'(ASYNC_CYC_RAW);
  // apb map
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] MODE_ADDR   = 8'h04;
  localparam logic [7:0] CMD_ADDR    = 8'h08;
  localparam logic [7:0] STATUS_ADDR = 8'h0C;
  localparam int CTRL_TERM_REQ = 0;
  localparam int CTRL_READ     = 1;
  localparam int CTRL_SREF     = 2;
  localparam int CTRL_DLL_OFF  = 3;
  localparam int CTRL_INIT     = 4;
  localparam int CMD_WRITE     = 0;
  localparam int CMD_CHOP      = 1;
  localparam logic [31:0] MODE_RESET = 32'h0008_1500;
  typedef enum logic [2:0] {
    ODT_SEL_OFF = 3'b001,
    ODT_SEL_NOM = 3'b010,
    ODT_SEL_WR  = 3'b100
  } odt_sel_type;
endpackage

// >>> odt_if.sv
// link between memory controller end and device termination end
`timescale 1ns/10ps
interface odt_if;
  logic       term_ctrl;
  logic       wr_cmd;
  logic       wr_chop;
  logic       rd_active;
  logic       self_refresh;
  logic       dll_off;
  logic       init_done;
  logic [2:0] nom_code;
  logic [1:0] wr_code;
  logic [1:0] al_code;
  logic [3:0] cas_write_latency;
  logic [3:0] cl;
  logic [1:0] burst_mode;
  modport host (output term_ctrl, wr_cmd, wr_chop, rd_active, self_refresh,
    dll_off, init_done, nom_code, wr_code, al_code, cas_write_latency, cl, burst_mode);
  modport device (input term_ctrl, wr_cmd, wr_chop, rd_active, self_refresh,
    dll_off, init_done, nom_code, wr_code, al_code, cas_write_latency, cl, burst_mode);
endinterface

// >>> odt_delay_line.sv
// shift register keeping the recent history of a few sampled bits
`timescale 1ns/10ps
module odt_delay_line #(
  parameter int W     = 3,
  parameter int DEPTH = 40
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic [W-1:0]              d,
  output logic      [DEPTH-1:0][W-1:0]   hist
);
  // one register per stage, so no packed word has several writers
  logic [W-1:0] stage_reg [DEPTH];
  genvar g;
  for (g = 0; g < DEPTH; g++) begin : g_stage
    if (g == 0) begin : g_first
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stage_reg[g] <= '0;
        end else begin
          stage_reg[g] <= d;
        end
      end
    end else begin : g_next
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stage_reg[g] <= '0;
        end else begin
          stage_reg[g] <= stage_reg[g-1];
        end
      end
    end
  end
  always_comb begin
    for (int k = 0; k < DEPTH; k++) begin
      hist[k] = stage_reg[k];
    end
  end
endmodule // odt_delay_line

// >>> odt_device.sv
// device end: nominal and dynamic on-die termination control
// Operation
// RULE1 - ignore pin in self refresh or both disabled
// RULE2 - synchronous normally, asynchronous when dll off
// RULE3 - write value only during write bursts
// RULE4 - three-bit nominal field enables, pin switches
// RULE5 - decode nominal codes to rzq fractions
// RULE6 - controller never programs nominal codes 110/111
// RULE7 - controller holds pin low in reads, refresh
// RULE8 - termination on only after init, not read
// RULE9 - nominal-only writes limited to rzq/2,4,6
// RULE10 - sync on/off cwl+al-2 after pin sample
// RULE11 - async on/off within 1 to 9 ns; here one delay tap plus the output register, two 25 ns clocks
// RULE12 - pin high at least 4 cycles
// RULE13 - pin high 6 cycles after full write
// RULE14 - dynamic switch automatic, back after burst
// RULE15 - dynamic enabled when either write bit set
// RULE16 - controller disables dynamic when dll off
// RULE17 - idle uses nominal with pin latencies
// RULE18 - switch to write value wl-2 after write
// RULE19 - switch back at 6 or 4 plus latency
// RULE20 - value undefined in changeover window
// RULE21 - nominal timing also governs dynamic mode
// RULE22 - decode write field to rzq fractions
// RULE23 - additive latency delays internal control
// RULE24 - track burst length per registered write
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
module odt_device #(
  parameter int DEPTH = 40
) (
  odt_if.device                 link,
  input  wire logic             pclk,
  input  wire logic             presetn,
  output logic                  term_on,
  output odt_pkg::odt_sel_type  term_sel,
  output logic [7:0]            term_ohms,
  output logic                  changeover,
  output logic                  async_mode
);
  localparam int HW = 3;
  localparam int PIN_BIT = 0;
  localparam int WR_BIT = 1;
  localparam int CHOP_BIT = 2;
  localparam logic [5:0] LAST_TAP = 6'(DEPTH);

  logic                   ignore_pin;
  logic                   pin_gated;
  logic                   dyn_en;
  logic                   chop_now;
  logic [5:0]             al_cyc;
  logic [5:0]             lat;
  logic [5:0]             pin_tap;
  logic [5:0]             end4_tap;
  logic [5:0]             end8_tap;
  logic [DEPTH-1:0][HW-1:0] hist;
  logic                   pin_late;
  logic                   wr_start;
  logic                   wr_end;
  logic                   wr_active_reg;
  logic                   wr_active_next;
  logic                   term_on_next;
  odt_pkg::odt_sel_type   sel_next;
  logic [7:0]             ohms_next;

  function automatic logic [7:0] nom_ohms(input logic [2:0] code);
    logic [7:0] r;
    r = 8'h00;
    case (code)
      odt_pkg::NOM_DIV4:  r = 8'(odt_pkg::RZQ_OHMS / 4); // RULE5
      odt_pkg::NOM_DIV2:  r = 8'(odt_pkg::RZQ_OHMS / 2);
      odt_pkg::NOM_DIV6:  r = 8'(odt_pkg::RZQ_OHMS / 6);
      odt_pkg::NOM_DIV12: r = 8'(odt_pkg::RZQ_OHMS / 12);
      odt_pkg::NOM_DIV8:  r = 8'(odt_pkg::RZQ_OHMS / 8);
      default:            r = 8'h00;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] wr_ohms(input logic [1:0] code);
    logic [7:0] r;
    r = 8'h00;
    case (code)
      odt_pkg::WR_DIV4: r = 8'(odt_pkg::RZQ_OHMS / 4); // RULE22
      odt_pkg::WR_DIV2: r = 8'(odt_pkg::RZQ_OHMS / 2);
      default:          r = 8'h00;
    endcase
    return r;
  endfunction

  // pin gating: self refresh, all-off, before init, during reads
  always_comb begin
    ignore_pin = link.self_refresh ||
      (link.nom_code == odt_pkg::NOM_OFF &&
       link.wr_code == odt_pkg::WR_OFF); // RULE1
    pin_gated = link.term_ctrl && !ignore_pin &&
      link.init_done && !link.rd_active; // RULE8
  end

  // reserved write code counts as enabled but gives no value
  assign dyn_en = link.wr_code != odt_pkg::WR_OFF; // RULE15

  // burst size of this write, fixed or picked per command
  always_comb begin
    unique case (link.burst_mode)
      odt_pkg::BURST_FIX4: chop_now = 1'b1;
      odt_pkg::BURST_OTF:  chop_now = link.wr_chop;
      default:             chop_now = 1'b0;
    endcase
  end

  // latency from cwl and additive latency
  always_comb begin
    unique case (link.al_code)
      odt_pkg::AL_CL1: al_cyc = {2'b00, link.cl} - 6'h01; // RULE23
      odt_pkg::AL_CL2: al_cyc = {2'b00, link.cl} - 6'h02;
      default:         al_cyc = 6'h00;
    endcase
    lat = {2'b00, link.cas_write_latency} + al_cyc - odt_pkg::LAT_OFFSET; // RULE10
    if (lat < 6'h01 || lat > LAST_TAP - 6'(odt_pkg::MIN_HIGH_LONG)) begin
      lat = 6'h01;
    end
  end

  // dll off: short fixed delay of one tap, no cwl or al latency
  assign pin_tap = link.dll_off ? odt_pkg::ASYNC_DELAY_CYC : lat; // RULE2 RULE11
  assign end4_tap = lat + 6'(odt_pkg::MIN_HIGH_SHORT);
  assign end8_tap = lat + 6'(odt_pkg::MIN_HIGH_LONG);

  // history of {chop, write, pin}; write bits carry burst size
  odt_delay_line #(
    .W     (HW),
    .DEPTH (DEPTH)
  ) u_hist (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({chop_now, link.wr_cmd, pin_gated}), // RULE24
    .hist    (hist)
  );

  always_comb begin
    pin_late = hist[pin_tap - 6'h01][PIN_BIT]; // RULE10 RULE17
    wr_start = hist[lat - 6'h01][WR_BIT]; // RULE18
    wr_end = (hist[end4_tap - 6'h01][WR_BIT] &&
              hist[end4_tap - 6'h01][CHOP_BIT]) ||
             (hist[end8_tap - 6'h01][WR_BIT] &&
              !hist[end8_tap - 6'h01][CHOP_BIT]); // RULE19
  end

  // a new burst starting wins over the end of the previous one
  always_comb begin
    wr_active_next = wr_active_reg;
    if (wr_end) begin
      wr_active_next = 1'b0;
    end
    if (wr_start) begin
      wr_active_next = 1'b1; // RULE14
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_active_reg <= 1'b0;
    end else begin
      wr_active_reg <= wr_active_next;
    end
  end

  // write value replaces nominal or nothing, only while on
  always_comb begin
    term_on_next = 1'b0;
    sel_next = odt_pkg::ODT_SEL_OFF;
    ohms_next = 8'h00;
    if (pin_late) begin // RULE21
      if (dyn_en && wr_active_next &&
          wr_ohms(link.wr_code) != 8'h00) begin
        sel_next = odt_pkg::ODT_SEL_WR; // RULE3
        ohms_next = wr_ohms(link.wr_code);
      end else if (nom_ohms(link.nom_code) != 8'h00) begin
        sel_next = odt_pkg::ODT_SEL_NOM; // RULE4 RULE17
        ohms_next = nom_ohms(link.nom_code);
      end
      term_on_next = sel_next != odt_pkg::ODT_SEL_OFF;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_on <= 1'b0;
      term_sel <= odt_pkg::ODT_SEL_OFF;
      term_ohms <= 8'h00;
    end else begin
      term_on <= term_on_next;
      term_sel <= sel_next;
      term_ohms <= ohms_next;
    end
  end

  // one cycle marking the skew window after nominal/write swaps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      changeover <= 1'b0;
    end else begin
      changeover <= term_on && term_on_next &&
        sel_next != term_sel; // RULE20
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      async_mode <= 1'b0;
    end else begin
      async_mode <= link.dll_off; // RULE2
    end
  end
endmodule // odt_device

// >>> odt_host.sv
// controller end: apb registers driving the termination link
`timescale 1ns/10ps
module odt_host (
  odt_if.host          link,
  input  wire logic    pclk,
  input  wire logic    presetn,
  input  wire logic    psel,
  input  wire logic    penable,
  input  wire logic    pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic         pready,
  output logic [31:0]  prdata,
  output logic         pslverr
);
  logic [4:0]  ctrl_reg;
  logic [31:0] mode_reg;
  logic        mode_err_reg;
  logic [3:0]  hold_reg;
  logic [3:0]  hold_next;
  logic        pin_next;
  logic        do_write;
  logic        wr_issue;
  logic        mode_ok;
  logic        blocked;
  logic [31:0] rd_mux;
  logic        addr_ok;

  assign do_write = psel && penable && pready && pwrite;
  assign wr_issue = do_write && paddr == odt_pkg::CMD_ADDR &&
    pwdata[odt_pkg::CMD_WRITE];

  // reserved codes and unsafe write-time nominal values refused
  always_comb begin
    mode_ok = pwdata[2:0] <= odt_pkg::NOM_DIV8 &&
      pwdata[5:4] != odt_pkg::WR_RSVD; // RULE6
    if (pwdata[5:4] == odt_pkg::WR_OFF && pwdata[2:0] != odt_pkg::NOM_OFF &&
        pwdata[2:0] > odt_pkg::NOM_DIV6) begin
      mode_ok = 1'b0; // RULE9
    end
  end

  always_comb begin
    addr_ok = paddr == odt_pkg::CTRL_ADDR || paddr == odt_pkg::MODE_ADDR ||
      paddr == odt_pkg::CMD_ADDR || paddr == odt_pkg::STATUS_ADDR;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      odt_pkg::CTRL_ADDR:   rd_mux = {27'h000_0000, ctrl_reg};
      odt_pkg::MODE_ADDR:   rd_mux = mode_reg;
      odt_pkg::STATUS_ADDR: rd_mux = {20'h0_0000, hold_reg, 5'h00,
        mode_err_reg, hold_reg != 4'h0, link.term_ctrl};
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  // no wait states: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= 5'h00;
    end else if (do_write && paddr == odt_pkg::CTRL_ADDR) begin
      ctrl_reg <= pwdata[4:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= odt_pkg::MODE_RESET;
      mode_err_reg <= 1'b0;
    end else if (do_write && paddr == odt_pkg::MODE_ADDR) begin
      if (mode_ok) begin
        mode_reg <= pwdata;
      end
      mode_err_reg <= !mode_ok;
    end
  end

  // pin forced low in reads and self refresh, raised only after init
  always_comb begin
    blocked = ctrl_reg[odt_pkg::CTRL_READ] || ctrl_reg[odt_pkg::CTRL_SREF];
    hold_next = (hold_reg != 4'h0) ? hold_reg - 4'h1 : 4'h0;
    if (blocked) begin
      pin_next = 1'b0; // RULE7
    end else if (link.term_ctrl && hold_reg > 4'h1) begin
      pin_next = 1'b1; // RULE12
    end else begin
      pin_next = ctrl_reg[odt_pkg::CTRL_TERM_REQ] &&
        ctrl_reg[odt_pkg::CTRL_INIT]; // RULE8
    end
    if (pin_next && !link.term_ctrl) begin
      hold_next = odt_pkg::MIN_HIGH_SHORT; // RULE12
    end
    if (wr_issue && pin_next) begin
      // chop bit only counts when the burst size is picked per command
      if ((pwdata[odt_pkg::CMD_CHOP] && mode_reg[21:20] == odt_pkg::BURST_OTF) ||
          mode_reg[21:20] == odt_pkg::BURST_FIX4) begin
        hold_next = (hold_next > odt_pkg::MIN_HIGH_SHORT) ?
          hold_next : odt_pkg::MIN_HIGH_SHORT; // RULE12
      end else begin
        hold_next = odt_pkg::MIN_HIGH_LONG; // RULE13
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.term_ctrl <= 1'b0;
      hold_reg <= 4'h0;
    end else begin
      link.term_ctrl <= pin_next;
      hold_reg <= hold_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.wr_cmd <= 1'b0;
      link.wr_chop <= 1'b0;
    end else begin
      link.wr_cmd <= wr_issue;
      link.wr_chop <= wr_issue && pwdata[odt_pkg::CMD_CHOP];
    end
  end

  // dynamic value not allowed with the dll off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.rd_active <= 1'b0;
      link.self_refresh <= 1'b0;
      link.dll_off <= 1'b0;
      link.init_done <= 1'b0;
      link.nom_code <= odt_pkg::NOM_OFF;
      link.wr_code <= odt_pkg::WR_OFF;
      link.al_code <= odt_pkg::AL_ZERO;
      link.cas_write_latency <= 4'h0;
      link.cl <= 4'h0;
      link.burst_mode <= odt_pkg::BURST_FIX8;
    end else begin
      link.rd_active <= ctrl_reg[odt_pkg::CTRL_READ];
      link.self_refresh <= ctrl_reg[odt_pkg::CTRL_SREF];
      link.dll_off <= ctrl_reg[odt_pkg::CTRL_DLL_OFF];
      link.init_done <= ctrl_reg[odt_pkg::CTRL_INIT];
      link.nom_code <= mode_reg[2:0];
      link.wr_code <= ctrl_reg[odt_pkg::CTRL_DLL_OFF] ?
        odt_pkg::WR_OFF : mode_reg[5:4]; // RULE16
      link.al_code <= mode_reg[9:8];
      link.cas_write_latency <= mode_reg[15:12];
      link.cl <= mode_reg[19:16];
      link.burst_mode <= mode_reg[21:20];
    end
  end
endmodule // odt_host

// >>> odt_checker.sv
// assertions on the termination link and the device outputs
`timescale 1ns/10ps
module odt_checker (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 term_ctrl,
  input wire logic                 wr_cmd,
  input wire logic                 wr_chop,
  input wire logic                 rd_active,
  input wire logic                 self_refresh,
  input wire logic                 dll_off,
  input wire logic                 init_done,
  input wire logic [2:0]           nom_code,
  input wire logic [1:0]           wr_code,
  input wire logic [1:0]           al_code,
  input wire logic [3:0]           cas_write_latency,
  input wire logic [1:0]           burst_mode,
  input wire logic                 term_on,
  input wire odt_pkg::odt_sel_type term_sel,
  input wire logic [7:0]           term_ohms,
  input wire logic                 changeover
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // synchronous timing checks only for cwl 5, al 0, so latency is 3
  wire logic       g0   = init_done && !self_refresh && !rd_active && nom_code != 3'h0;
  wire logic       sync = g0 && !dll_off && cas_write_latency == 4'h5 && al_code == 2'h0;
  wire logic       dyn  = wr_code == odt_pkg::WR_DIV4 || wr_code == odt_pkg::WR_DIV2;
  wire logic       chop = burst_mode == odt_pkg::BURST_FIX4 ||
                          (burst_mode == odt_pkg::BURST_OTF && wr_chop);
  wire logic [7:0] exp_ohm = (term_sel == odt_pkg::ODT_SEL_WR) ?
                             ((wr_code == odt_pkg::WR_DIV4) ? 8'h3C : 8'h78) :
                             (nom_code == 3'h1) ? 8'h3C : (nom_code == 3'h2) ? 8'h78 :
                             (nom_code == 3'h3) ? 8'h28 : (nom_code == 3'h4) ? 8'h14 :
                             (nom_code == 3'h5) ? 8'h1E : 8'h00;

  a_sync_on: assert property (
    $rose(term_ctrl) && sync && !term_on |-> !term_on [*4] ##1 term_on)
    else $error("termination on at wrong cycle");
  a_sync_off: assert property (
    $fell(term_ctrl) && sync && term_on |-> term_on [*4] ##1 !term_on)
    else $error("termination off at wrong cycle");
  a_min_high_short: assert property (
    $rose(term_ctrl) || (wr_cmd && term_ctrl && chop) |-> term_ctrl [*4])
    else $error("pin high under four cycles");
  a_min_high_long: assert property (
    wr_cmd && term_ctrl && !chop |-> term_ctrl [*6])
    else $error("pin high under six cycles after write");
  a_read_pin_low: assert property (
    (rd_active || self_refresh) && $past(rd_active || self_refresh) |-> !term_ctrl)
    else $error("pin high during read or refresh");
  a_init_pin_low: assert property (!init_done |-> !term_ctrl)
    else $error("pin high before init");
  a_nominal_off: assert property (
    $rose(term_ctrl) && nom_code == 3'h0 |-> !term_on [*6])
    else $error("termination on with nominal off");
  a_async_on: assert property (
    $rose(term_ctrl) && g0 && dll_off && !term_on |-> !term_on [*2] ##1 term_on)
    else $error("async turn on late");
  a_write_switch: assert property (
    wr_cmd && term_on && term_ctrl && sync && dyn |->
    ##3 term_sel == odt_pkg::ODT_SEL_NOM ##1 term_sel == odt_pkg::ODT_SEL_WR)
    else $error("write value at wrong cycle");
  a_back_chop: assert property (
    wr_cmd && term_on && sync && dyn && chop |->
    ##7 term_sel == odt_pkg::ODT_SEL_WR ##1 term_sel == odt_pkg::ODT_SEL_NOM)
    else $error("chop write return at wrong cycle");
  a_back_full: assert property (
    wr_cmd && term_on && sync && dyn && !chop |->
    ##9 term_sel == odt_pkg::ODT_SEL_WR ##1 term_sel == odt_pkg::ODT_SEL_NOM)
    else $error("full write return at wrong cycle");
  a_ohms_value: assert property (
    term_on && !changeover && $stable(nom_code) &&
    term_sel != odt_pkg::ODT_SEL_OFF |-> term_ohms == exp_ohm)
    else $error("termination value wrong");
  a_dll_no_dyn: assert property (dll_off |-> wr_code == odt_pkg::WR_OFF)
    else $error("write value enabled with dll off");
endmodule // odt_checker

// >>> tb_top.sv
// self-checking bench: controller and device ends joined by the link
`timescale 1ns/10ps
module tb_top;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
  logic                 term_on, changeover, async_mode, ok;
  logic [7:0]           paddr, term_ohms, ohm;
  logic [31:0]          pwdata, prdata, r, m, cur;
  logic [2:0]           nom;
  logic [1:0]           wr;
  odt_pkg::odt_sel_type term_sel;
  int                   bad_count, checks, i;
  // rows: legal flag, nominal code, write code, ohms when on
  logic [13:0]          rows [10] = '{{1'b1, 3'h1, 2'h0, 8'h3C}, {1'b1, 3'h2, 2'h0, 8'h78},
    {1'b1, 3'h3, 2'h0, 8'h28}, {1'b0, 3'h4, 2'h0, 8'h00}, {1'b0, 3'h5, 2'h0, 8'h00},
    {1'b0, 3'h6, 2'h1, 8'h00}, {1'b1, 3'h4, 2'h1, 8'h14}, {1'b1, 3'h5, 2'h2, 8'h1E},
    {1'b0, 3'h7, 2'h2, 8'h00}, {1'b1, 3'h0, 2'h1, 8'h00}};

  odt_if link_if ();
  odt_host odt_host_inst (.link(link_if.host), .pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr);
  odt_device #(.DEPTH(40)) odt_device_inst (.link(link_if.device), .pclk, .presetn,
    .term_on, .term_sel, .term_ohms, .changeover, .async_mode);
  odt_checker odt_checker_inst (.pclk, .presetn, .term_ctrl(link_if.term_ctrl),
    .wr_cmd(link_if.wr_cmd), .wr_chop(link_if.wr_chop), .rd_active(link_if.rd_active),
    .self_refresh(link_if.self_refresh), .dll_off(link_if.dll_off),
    .init_done(link_if.init_done), .nom_code(link_if.nom_code), .wr_code(link_if.wr_code),
    .al_code(link_if.al_code), .cas_write_latency(link_if.cas_write_latency), .burst_mode(link_if.burst_mode),
    .term_on, .term_sel, .term_ohms, .changeover);

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // master waits on pready without assuming a latency
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    serr = pslverr;
    if (n >= 50) chk("pready", 0, 1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wsel(input odt_pkg::odt_sel_type s);
    int n;
    n = 0;
    while (term_sel !== s && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk("term_sel", term_sel, s);
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // generous bound, the sequence needs a few hundred cycles
  initial begin
    #1000000;
    bad_count++;
    stop_test;
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    bad_count = 0;
    checks = 0;
    tick(16);
    presetn <= 1'b1;
    apb(0, odt_pkg::MODE_ADDR, 0);
    chk("mode reset", r, odt_pkg::MODE_RESET);
    cur = r;
    apb(0, odt_pkg::STATUS_ADDR, 0);
    chk("status reset", r, 0);
    apb(0, 8'h10, 0);
    chk("unmapped", {r[30:0], serr}, 32'h0000_0001);
    chk("sel reset", term_sel, odt_pkg::ODT_SEL_OFF);
    apb(1, odt_pkg::CTRL_ADDR, 32'h0000_0001);
    tick(8);
    chk("pin no init", link_if.term_ctrl, 0);
    $display("test reset done");
    for (i = 0; i < 10; i++) begin
      {ok, nom, wr, ohm} = rows[i];
      m = 32'h0008_5000 | {26'h0, wr, 1'b0, nom};
      apb(1, odt_pkg::MODE_ADDR, m);
      if (ok) cur = m;
      apb(0, odt_pkg::MODE_ADDR, 0);
      chk("mode", r, cur);
      apb(0, odt_pkg::STATUS_ADDR, 0);
      chk("mode err", r[2], !ok);
      if (ok) begin
        apb(1, odt_pkg::CTRL_ADDR, 32'h0000_0011);
        tick(12);
        chk("term_on", term_on, nom != 3'h0);
        chk("ohms", term_ohms, ohm);
        apb(1, odt_pkg::CTRL_ADDR, 32'h0000_0010);
        tick(12);
        chk("term_off", term_on, 0);
      end
    end
    $display("test mode rows done");
    for (i = 0; i < 2; i++) begin
      apb(1, odt_pkg::MODE_ADDR, 32'h0008_5012 | (i ? 32'h0010_0000 : 32'h0));
      apb(1, odt_pkg::CTRL_ADDR, 32'h0000_0011);
      tick(10);
      apb(1, odt_pkg::CMD_ADDR, i ? 32'h0000_0003 : 32'h0000_0001);
      wsel(odt_pkg::ODT_SEL_WR);
      chk("changeover", changeover, 1);
      tick(2);
      chk("write ohms", term_ohms, 8'h3C);
      wsel(odt_pkg::ODT_SEL_NOM);
      apb(1, odt_pkg::CTRL_ADDR, 32'h0000_0010);
      tick(12);
    end
    $display("test dynamic done");
    apb(1, odt_pkg::MODE_ADDR, 32'h0008_5002);
    apb(1, odt_pkg::CTRL_ADDR, 32'h0000_0011);
    tick(8);
    apb(1, odt_pkg::CMD_ADDR, 32'h0000_0001);
    apb(1, odt_pkg::CTRL_ADDR, 32'h0000_0010);
    tick(2);
    chk("pin held", link_if.term_ctrl, 1);
    tick(12);
    chk("pin released", link_if.term_ctrl, 0);
    $display("test hold done");
    for (i = 0; i < 2; i++) begin
      apb(1, odt_pkg::CTRL_ADDR, 32'h0000_0011);
      tick(10);
      apb(1, odt_pkg::CTRL_ADDR, i ? 32'h0000_0015 : 32'h0000_0013);
      tick(2);
      chk("pin forced low", link_if.term_ctrl, 0);
      tick(8);
      chk("term off", term_on, 0);
      apb(1, odt_pkg::CTRL_ADDR, 32'h0000_0010);
      tick(8);
    end
    $display("test read refresh done");
    apb(1, odt_pkg::MODE_ADDR, 32'h0008_5102);
    apb(1, odt_pkg::CTRL_ADDR, 32'h0000_0011);
    tick(12);
    chk("al not yet on", term_on, 0);
    tick(1);
    chk("al on", term_on, 1);
    apb(1, odt_pkg::CTRL_ADDR, 32'h0000_0010);
    tick(14);
    $display("test additive latency done");
    apb(1, odt_pkg::MODE_ADDR, 32'h0008_5012);
    apb(1, odt_pkg::CTRL_ADDR, 32'h0000_0018);
    tick(4);
    chk("dll off write code", link_if.wr_code, 0);
    apb(1, odt_pkg::CTRL_ADDR, 32'h0000_0019);
    tick(6);
    chk("async on", term_on, 1);
    chk("async flag", async_mode, 1);
    presetn <= 1'b0;
    tick(2);
    chk("reset off", term_on, 0);
    chk("reset sel", term_sel, odt_pkg::ODT_SEL_OFF);
    presetn <= 1'b1;
    apb(0, odt_pkg::MODE_ADDR, 0);
    chk("mode again", r, odt_pkg::MODE_RESET);
    $display("test async reset done");
    stop_test;
  end
endmodule // tb_top
